// *** hw/alert_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "alert_map.svh"
module alert_ctrl #(
	parameter int PULSE_CYCLES = `ALERT_PULSE_MS * `CLK_FREQ_KHZ,
	parameter int PERIOD_CYCLES = `ALERT_PERIOD_MS * `CLK_FREQ_KHZ,
	parameter int CNT_W = 20
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [7:0] reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic clk_err_event,
	input wire logic pll_lock_event,
	output logic alert_pin
);
	import alert_pkg::*;

	logic [7:0] config_reg, config_next;
	logic [7:0] mask_reg, mask_next;
	logic [7:0] flags_reg, flags_next;
	logic [7:0] rdata_reg, rdata_next;
	logic pin_reg, pin_next;
	logic [7:0] events;
	logic [7:0] visible;
	logic [7:0] unmasked;
	logic page_hit;
	logic pending;
	logic active;
	alert_mode_t mode;
	alert_timer_if tif ();

	alert_pulse_timer #(
		.CNT_W(CNT_W),
		.PULSE_CYCLES(PULSE_CYCLES),
		.PERIOD_CYCLES(PERIOD_CYCLES)
	) u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.ce(ce),
		.tif(tif)
	);

	always_comb begin
		events = 8'h00;
		events[`SRC_CLK_ERR_BIT] = clk_err_event;
		events[`SRC_PLL_LOCK_BIT] = pll_lock_event;
	end

	assign mode = alert_mode_t'(config_reg[`CFG_MODE_HI:`CFG_MODE_LO]);
	assign page_hit = (reg_page == `ALERT_PAGE);
	assign unmasked = flags_reg & ~mask_reg;
	assign pending = |unmasked;
	assign visible = config_reg[`CFG_READBACK_BIT] ? unmasked : flags_reg;
	assign tif.repeat_en = (mode == MODE_REPEAT) && pending;
	assign tif.shot_start = (mode == MODE_ONESHOT) && |(events & ~mask_reg);

	always_comb begin
		unique case (mode)
			MODE_LEVEL: active = pending;
			MODE_REPEAT: active = pending && tif.phase_on;
			MODE_ONESHOT: active = tif.phase_on;
			MODE_RESERVED: active = 1'b0;
		endcase
	end

	always_comb begin
		config_next = config_reg;
		mask_next = mask_reg;
		flags_next = flags_reg;
		rdata_next = rdata_reg;
		if (reg_wr && page_hit && reg_addr == `ALERT_CONFIG_ADDR) begin
			config_next = reg_wdata & 8'hE4;
		end
		if (reg_wr && page_hit && reg_addr == `ALERT_MASK_ADDR) begin
			mask_next = reg_wdata;
		end
		if (reg_rd) begin
			rdata_next = 8'h00;
			if (page_hit) begin
				unique case (reg_addr)
					`ALERT_CONFIG_ADDR: rdata_next = config_reg;
					`ALERT_MASK_ADDR: rdata_next = mask_reg;
					`ALERT_FLAGS_ADDR: begin
						rdata_next = visible & 8'hC0;
						flags_next = flags_reg & ~visible;
					end
					default: rdata_next = 8'h00;
				endcase
			end
		end
		flags_next = (flags_next | events) & 8'hC0;
		pin_next = config_reg[`CFG_POL_BIT] ? active : ~active;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			config_reg <= `ALERT_CONFIG_RESET;
			mask_reg <= `ALERT_MASK_RESET;
			flags_reg <= `ALERT_FLAGS_RESET;
			rdata_reg <= 8'h00;
			pin_reg <= 1'b1;
		end else if (ce) begin
			config_reg <= config_next;
			mask_reg <= mask_next;
			flags_reg <= flags_next;
			rdata_reg <= rdata_next;
			pin_reg <= pin_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign alert_pin = pin_reg;
endmodule
`default_nettype wire

// *** hw/alert_map.svh ***
`ifndef ALERT_MAP_SVH
`define ALERT_MAP_SVH
`define ALERT_PAGE 8'h00
`define ALERT_CONFIG_ADDR 8'h32
`define ALERT_MASK_ADDR 8'h33
`define ALERT_FLAGS_ADDR 8'h36
`define ALERT_CONFIG_RESET 8'h00
`define ALERT_MASK_RESET 8'hFF
`define ALERT_FLAGS_RESET 8'h00
`define CFG_POL_BIT 7
`define CFG_MODE_HI 6
`define CFG_MODE_LO 5
`define CFG_READBACK_BIT 2
`define SRC_CLK_ERR_BIT 7
`define SRC_PLL_LOCK_BIT 6
`define CLK_FREQ_KHZ 25000
`define ALERT_PULSE_MS 2
`define ALERT_PERIOD_MS 4
`endif

// *** hw/alert_pkg.sv ***
package alert_pkg;
	typedef enum logic [1:0] {
		MODE_LEVEL = 2'b00,
		MODE_RESERVED = 2'b01,
		MODE_REPEAT = 2'b10,
		MODE_ONESHOT = 2'b11
	} alert_mode_t;
	typedef enum logic [1:0] {
		TMR_IDLE = 2'b00,
		TMR_ON = 2'b01,
		TMR_OFF = 2'b10
	} timer_state_t;
endpackage

// *** hw/alert_timer_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface alert_timer_if;
	logic repeat_en;
	logic shot_start;
	logic phase_on;
	modport ctrl (output repeat_en, output shot_start, input phase_on);
	modport timer (input repeat_en, input shot_start, output phase_on);
endinterface
`default_nettype wire

// *** hw/alert_pulse_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module alert_pulse_timer #(
	parameter int CNT_W = 20,
	parameter int PULSE_CYCLES = 50000,
	parameter int PERIOD_CYCLES = 100000
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	alert_timer_if.timer tif
);
	import alert_pkg::*;
	localparam logic [CNT_W-1:0] ON_LAST = CNT_W'(PULSE_CYCLES - 1);
	localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(PERIOD_CYCLES - PULSE_CYCLES - 1);
	timer_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + CNT_W'(1);
		unique case (state_reg)
			TMR_IDLE: begin
				cnt_next = '0;
				if (tif.shot_start || tif.repeat_en) begin
					state_next = TMR_ON;
				end
			end
			TMR_ON: begin
				if (tif.shot_start) begin
					cnt_next = '0;
				end else if (cnt_reg == ON_LAST) begin
					cnt_next = '0;
					state_next = tif.repeat_en ? TMR_OFF : TMR_IDLE;
				end
			end
			TMR_OFF: begin
				if (tif.shot_start) begin
					cnt_next = '0;
					state_next = TMR_ON;
				end else if (!tif.repeat_en) begin
					cnt_next = '0;
					state_next = TMR_IDLE;
				end else if (cnt_reg == OFF_LAST) begin
					cnt_next = '0;
					state_next = TMR_ON;
				end
			end
			default: begin
				cnt_next = '0;
				state_next = TMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= TMR_IDLE;
			cnt_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	assign tif.phase_on = (state_reg == TMR_ON);
endmodule
`default_nettype wire

// *** testbench/alert_ctrl_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module alert_ctrl_sva (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [7:0] reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic alert_pin
);
	logic rd_hit;
	logic wr_hit;
	assign rd_hit = reg_rd && ce && reg_page == 8'h00;
	assign wr_hit = reg_wr && ce && reg_page == 8'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_reset_idle: assert property ($rose(reset_n) |-> reg_rdata == 8'h00 && alert_pin)
		else $error("outputs not idle after reset");
	a_rdata_hold: assert property (!(reg_rd && ce) |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_ce_freeze: assert property (!ce |=> $stable(alert_pin) && $stable(reg_rdata))
		else $error("state moved while clock enable low");
	a_page_refused: assert property (reg_rd && ce && reg_page != 8'h00 |=> reg_rdata == 8'h00)
		else $error("other page read not zero");
	a_unmapped_zero: assert property (rd_hit && !(reg_addr inside {8'h32, 8'h33, 8'h36}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_cfg_reserved: assert property (rd_hit && reg_addr == 8'h32 |=> (reg_rdata & 8'h1B) == 8'h00)
		else $error("config reserved bits not zero");
	a_flags_low: assert property (rd_hit && reg_addr == 8'h36 |=> reg_rdata[5:0] == 6'h00)
		else $error("flag low bits not zero");
	a_mask_rw: assert property (wr_hit && reg_addr == 8'h33 ##1 rd_hit && !reg_wr && reg_addr == 8'h33
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("mask readback differs");
	c_flag_read: cover property (rd_hit && reg_addr == 8'h36);
	c_pin_rise: cover property ($rose(alert_pin));
	c_ce_low: cover property (!ce && reg_wr);
endmodule
bind alert_ctrl alert_ctrl_sva alert_ctrl_sva_inst (.clk, .reset_n, .ce, .reg_page, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rd, .reg_rdata, .alert_pin);
`default_nettype wire

// *** testbench/alert_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module alert_host_model (
	input wire logic alert_pin,
	input wire logic pol,
	output logic active
);
	assign active = (alert_pin === pol);
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 0, reset_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, clk_err_event = 0, pll_lock_event = 0;
	logic [7:0] reg_page = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, m;
	logic alert_pin, active, pol = 0;
	int errors = 0, checked = 0;
	int e[4] = '{32, 0, 16, 8};
	always #20 clk = ~clk;
	alert_ctrl #(.PULSE_CYCLES(8), .PERIOD_CYCLES(16)) alert_ctrl_inst (.clk, .reset_n, .ce, .reg_page, .reg_addr,
		.reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .clk_err_event, .pll_lock_event, .alert_pin);
	alert_host_model alert_host_model_inst (.alert_pin, .pol, .active);
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] x);
		checked++;
		if (s !== x) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", n, x, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] x);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		chk("rdata", reg_rdata, x);
	endtask
	task meas(input int n, input int x);
		int k;
		k = 0;
		repeat (n) begin
			cyc(1);
			k += active;
		end
		chk("active", k[7:0], x[7:0]);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		void'($urandom(50930));
		cyc(6);
		reset_n = 1;
		rd(8'h32, 8'h00);
		rd(8'h33, 8'hFF);
		rd(8'h36, 8'h00);
		rd(8'h34, 8'h00);
		reg_page = 8'h01;
		rd(8'h33, 8'h00);
		reg_page = 8'h00;
		$display("reset test done");
		wr(8'h32, 8'hFF);
		rd(8'h32, 8'hE4);
		repeat (4) begin
			m = $urandom;
			wr(8'h33, m);
			rd(8'h33, m);
		end
		ce = 0;
		wr(8'h33, ~m);
		ce = 1;
		rd(8'h33, m);
		$display("register test done");
		wr(8'h33, 8'hBF);
		wr(8'h32, 8'h04);
		clk_err_event = 1;
		cyc(1);
		clk_err_event = 0;
		cyc(3);
		chk("pin", {7'h00, alert_pin}, 8'h01);
		rd(8'h36, 8'h00);
		wr(8'h32, 8'h00);
		rd(8'h36, 8'h80);
		rd(8'h36, 8'h00);
		wr(8'h33, 8'h3F);
		pll_lock_event = 1;
		cyc(1);
		pll_lock_event = 0;
		cyc(2);
		chk("pin", {7'h00, alert_pin}, 8'h00);
		rd(8'h36, 8'h40);
		cyc(2);
		chk("pin", {7'h00, alert_pin}, 8'h01);
		$display("level test done");
		pol = 1;
		for (int i = 0; i < 4; i++) begin
			wr(8'h32, {1'b1, 2'(i), 5'h00});
			pll_lock_event = 1;
			cyc(1);
			pll_lock_event = 0;
			cyc(i == 3 ? 0 : 4);
			meas(i == 3 ? 40 : 32, e[i]);
			rd(8'h36, 8'h40);
			cyc(4);
		end
		$display("mode test done");
		give_verdict;
	end
endmodule
`default_nettype wire
